// File: mdc_modem_coding.sv
// modem data coding, tone selection, data clocks and set-ready logic
`include "mdc_params.svh"
`default_nettype none
// Notes on behaviour
// - dial code picks one row, one column tone
// - guard tone 1800 Hz low, 553.846 high
// - 1200 bps: each bit pair is one phase change
// - 600 bps: each bit is a phase change
// - scrambler in path for phase coding only, descrambler always in path
// - receive clock square, rising mid bit
// - transmit clock runs at selected bit rate
// - receive data held mark without line signal
// - set-ready on in every state but idle, off in test
// - async characters of 8 to 11 bits
// - low-speed mark/space tones by call direction
// - carrier 1200 originate, 2400 answer
// - tone flag follows band energy while call request set, 17 ms
// - set-ready drops 50 ms after ready off, or 50 ms after the spaces when space disconnect is set
module mdc_modem_coding #(
  parameter int unsigned TX_HALF_HI = `MDC_CLK_KHZ * 1000 / (2 * `MDC_RATE_HI_BPS),
  parameter int unsigned TX_HALF_LO = `MDC_CLK_KHZ * 1000 / (2 * `MDC_RATE_LO_BPS),
  parameter int unsigned TONE_CYC   = `MDC_TONE_RESP_MS * `MDC_CLK_KHZ,
  parameter int unsigned DROP_CYC   = `MDC_DSR_DROP_MS * `MDC_CLK_KHZ,
  parameter int unsigned SPACE_CYC  = `MDC_SPACE_MAX_MS * `MDC_CLK_KHZ
) (
  input  wire logic        I_CLK,
  input  wire logic        I_SYS_RST,
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [7:0]  I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  input  wire logic        I_TXD,
  input  wire logic        I_RX_LINE_CLK,
  input  wire logic        I_RX_LINE_BIT,
  input  wire logic        I_LINE_SIGNAL_DETECT,
  input  wire logic        I_TONE_ENERGY,
  output logic             O_TRANSMIT_DATA_CLOCK_OUT,
  output logic             O_RECEIVE_DATA_CLOCK_OUT,
  output logic             O_RXD,
  output logic             O_DSR,
  output logic      [1:0]  O_TX_PHASE,
  output logic             O_TX_SYM_STB,
  output logic      [11:0] O_TONE_A_HZ,
  output logic      [11:0] O_TONE_B_HZ,
  output logic      [20:0] O_GUARD_MILLIHZ
);
  logic [4:0]  pins;
  logic [4:0]  meta;
  logic [4:0]  sync;
  logic [10:0] ctrl;
  logic [7:0]  txdata;
  logic        ferr;
  logic        tone_det;
  logic [25:0] tx_cnt;
  logic [25:0] tx_half;
  logic        tx_take;
  logic        tx_enc_stb;
  logic        tx_src;
  logic        fsk_bit;
  logic        pair_half;
  logic        pair_first;
  logic        lclk_d;
  logic        rx_stb_d;
  logic [3:0]  fr_cnt;
  logic [4:0]  char_len;
  logic [25:0] dsr_cnt;
  logic [2:0]  idx;
  logic [31:0] rd_val;
  logic        dial;
  logic        psk;
  logic        wr_take;
  mdc_pkg::mdc_dsr_state_type dsr_state;
  mdc_bit_if tx_b ();
  mdc_bit_if rx_b ();

  // outside inputs pass two flip-flops
  assign pins = {I_TXD, I_RX_LINE_CLK, I_RX_LINE_BIT, I_LINE_SIGNAL_DETECT, I_TONE_ENERGY};
  genvar g;
  generate
    for (g = 0; g < 5; g++)
    begin : g_sync
      always_ff @(posedge I_CLK or posedge I_SYS_RST)
      begin
        if (I_SYS_RST)
        begin
          meta[g] <= 1'b0;
          sync[g] <= 1'b0;
        end
        else
        begin
          meta[g] <= pins[g];
          sync[g] <= meta[g];
        end
      end
    end
  endgenerate

  // register index from byte address
  function automatic logic [2:0] reg_index(input logic [7:0] a);
    unique case (a)
      `MDC_A_CTRL:   reg_index = 3'h0;
      `MDC_A_TXDATA: reg_index = 3'h1;
      `MDC_A_STATUS: reg_index = 3'h2;
      `MDC_A_TONE:   reg_index = 3'h3;
      default:       reg_index = 3'h4;
    endcase
  endfunction

  // keypad tone: high selects column group
  function automatic mdc_pkg::mdc_hz_type dtmf_hz(input logic [3:0] c, input logic high);
    mdc_pkg::mdc_hz_type row;
    mdc_pkg::mdc_hz_type col;
    unique case (c)
      4'h1, 4'h2, 4'h3, 4'hB: row = `MDC_HZ_R697;
      4'h4, 4'h5, 4'h6, 4'hC: row = `MDC_HZ_R770;
      4'h7, 4'h8, 4'h9, 4'hD: row = `MDC_HZ_R852;
      4'h0, 4'hA, 4'hE, 4'hF: row = `MDC_HZ_R941;
    endcase
    unique case (c)
      4'h1, 4'h4, 4'h7, 4'hA: col = `MDC_HZ_C1209;
      4'h0, 4'h2, 4'h5, 4'h8: col = `MDC_HZ_C1336;
      4'h3, 4'h6, 4'h9, 4'hE: col = `MDC_HZ_C1477;
      4'hB, 4'hC, 4'hD, 4'hF: col = `MDC_HZ_C1633;
    endcase
    dtmf_hz = high ? col : row;
  endfunction

  // mode decode
  assign idx      = reg_index(I_PADDR);
  assign wr_take  = I_PSEL & I_PENABLE & O_PREADY & I_PWRITE;
  assign dial     = ctrl[`MDC_C_CALL_REQ] & ctrl[`MDC_C_DTMF];
  assign psk      = ~dial & ~ctrl[`MDC_C_FSK];
  assign char_len = `MDC_CHAR_MIN + {3'h0, ctrl[`MDC_C_CLEN_HI:`MDC_C_CLEN_LO]};

  // read data mux
  always_comb
  begin
    rd_val = 32'h00000000;
    unique case (idx)
      3'h0: rd_val = {21'h000000, ctrl};
      3'h1: rd_val = {24'h000000, txdata};
      3'h2: rd_val = {26'h0000000, dsr_state, ferr, tone_det, sync[1], O_DSR};
      3'h3: rd_val = {4'h0, O_TONE_B_HZ, 4'h0, O_TONE_A_HZ};
      3'h4: rd_val = 32'h00000000;
    endcase
  end

  // bus answer: ready in first access cycle
  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      O_PREADY  <= 1'b0;
      O_PSLVERR <= 1'b0;
      O_PRDATA  <= 32'h00000000;
    end
    else
    begin
      O_PREADY <= I_PSEL & ~I_PENABLE;
      if (I_PSEL & ~I_PENABLE)
      begin
        O_PSLVERR <= (idx == 3'h4);
        O_PRDATA  <= rd_val;
      end
    end
  end

  // writable registers
  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      ctrl   <= `MDC_CTRL_RST;
      txdata <= 8'h00;
    end
    else if (wr_take)
    begin
      if (idx == 3'h0)
        ctrl <= I_PWDATA[10:0];
      if (idx == 3'h1)
        txdata <= I_PWDATA[7:0];
    end
  end

  // transmit data clock divider
  assign tx_half = ctrl[`MDC_C_R600] ? 26'(TX_HALF_LO) : 26'(TX_HALF_HI);
  assign tx_take = (tx_cnt >= tx_half - 26'h1) & ~O_TRANSMIT_DATA_CLOCK_OUT;
  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      tx_cnt                    <= 26'h0000000;
      O_TRANSMIT_DATA_CLOCK_OUT <= 1'b0;
    end
    else if (tx_cnt >= tx_half - 26'h1)
    begin
      tx_cnt                    <= 26'h0000000;
      O_TRANSMIT_DATA_CLOCK_OUT <= ~O_TRANSMIT_DATA_CLOCK_OUT;
    end
    else
      tx_cnt <= tx_cnt + 26'h1;
  end

  // spaces replace data during disconnect
  assign tx_src      = (dsr_state == mdc_pkg::DSR_SPACE) ? 1'b0 : sync[4];
  assign tx_b.bit_in = tx_src;
  assign tx_b.stb    = tx_take;
  mdc_scrambler #(.DESCRAMBLE(1'b0)) u_tx_scr (
    .i_clk (I_CLK),
    .i_rst (I_SYS_RST),
    .b     (tx_b)
  );

  // phase encoder after scrambler
  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      tx_enc_stb   <= 1'b0;
      fsk_bit      <= 1'b1;
      pair_half    <= 1'b0;
      pair_first   <= 1'b0;
      O_TX_PHASE   <= 2'h0;
      O_TX_SYM_STB <= 1'b0;
    end
    else
    begin
      tx_enc_stb   <= tx_take;
      O_TX_SYM_STB <= 1'b0;
      if (tx_take)
        fsk_bit <= tx_src;
      if (tx_enc_stb & psk & ctrl[`MDC_C_R600])
      begin
        O_TX_PHASE   <= O_TX_PHASE + (tx_b.bit_out ? 2'h3 : 2'h1);
        O_TX_SYM_STB <= 1'b1;
        pair_half    <= 1'b0;
      end
      else if (tx_enc_stb & psk & ~pair_half)
      begin
        pair_first <= tx_b.bit_out;
        pair_half  <= 1'b1;
      end
      else if (tx_enc_stb & psk)
      begin
        // dibit 00,01,11,10 -> 90,0,270,180 degrees
        unique case ({pair_first, tx_b.bit_out})
          2'b00: O_TX_PHASE <= O_TX_PHASE + 2'h1;
          2'b01: O_TX_PHASE <= O_TX_PHASE;
          2'b11: O_TX_PHASE <= O_TX_PHASE + 2'h3;
          2'b10: O_TX_PHASE <= O_TX_PHASE + 2'h2;
        endcase
        O_TX_SYM_STB <= 1'b1;
        pair_half    <= 1'b0;
      end
    end
  end

  // tone and carrier selection per mode
  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      O_TONE_A_HZ     <= 12'h000;
      O_TONE_B_HZ     <= 12'h000;
      O_GUARD_MILLIHZ <= `MDC_GUARD_HI_MHZ;
    end
    else
    begin
      O_GUARD_MILLIHZ <= ctrl[`MDC_C_GUARD_SEL] ? `MDC_GUARD_LO_MHZ
                                               : `MDC_GUARD_HI_MHZ;
      O_TONE_B_HZ     <= 12'h000;
      if (dial)
      begin
        O_TONE_A_HZ <= dtmf_hz(txdata[3:0], 1'b0);
        O_TONE_B_HZ <= dtmf_hz(txdata[3:0], 1'b1);
      end
      else if (ctrl[`MDC_C_FSK] & ctrl[`MDC_C_ANS])
        O_TONE_A_HZ <= fsk_bit ? `MDC_HZ_FA_MARK : `MDC_HZ_FA_SPACE;
      else if (ctrl[`MDC_C_FSK])
        O_TONE_A_HZ <= fsk_bit ? `MDC_HZ_FO_MARK : `MDC_HZ_FO_SPACE;
      else
        O_TONE_A_HZ <= ctrl[`MDC_C_ANS] ? `MDC_HZ_ANS : `MDC_HZ_ORIG;
    end
  end

  // receive path: descramble on line clock rise
  assign rx_b.bit_in = sync[2];
  assign rx_b.stb    = sync[3] & ~lclk_d;
  mdc_scrambler #(.DESCRAMBLE(1'b1)) u_rx_scr (
    .i_clk (I_CLK),
    .i_rst (I_SYS_RST),
    .b     (rx_b)
  );

  // receive data clamp and mid-bit clock
  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      lclk_d                   <= 1'b0;
      rx_stb_d                 <= 1'b0;
      O_RXD                    <= 1'b1;
      O_RECEIVE_DATA_CLOCK_OUT <= 1'b0;
    end
    else
    begin
      lclk_d                   <= sync[3];
      rx_stb_d                 <= rx_b.stb;
      O_RECEIVE_DATA_CLOCK_OUT <= ~sync[3];
      if (~sync[1])
        O_RXD <= 1'b1;
      else if (rx_stb_d)
        O_RXD <= rx_b.bit_out;
    end
  end

  // async framing check on received characters
  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      fr_cnt <= 4'h0;
      ferr   <= 1'b0;
    end
    else
    begin
      if (wr_take & (idx == 3'h2) & I_PWDATA[`MDC_S_FERR])
        ferr <= 1'b0;
      if (rx_stb_d & sync[1])
      begin
        if (fr_cnt == 4'h0)
          fr_cnt <= rx_b.bit_out ? 4'h0 : 4'h1;
        else if ({1'b0, fr_cnt} == char_len - 5'h1)
        begin
          fr_cnt <= 4'h0;
          if (~rx_b.bit_out)
            ferr <= 1'b1;
        end
        else
          fr_cnt <= fr_cnt + 4'h1;
      end
    end
  end

  // tone flag only while call request set
  mdc_stable_filter #(.N(TONE_CYC)) u_tone (
    .i_clk   (I_CLK),
    .i_rst   (I_SYS_RST),
    .i_level (sync[0] & ctrl[`MDC_C_CALL_REQ]),
    .o_level (tone_det)
  );

  // data set ready sequencing
  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      dsr_state <= mdc_pkg::DSR_IDLE;
      dsr_cnt   <= 26'h0000000;
    end
    else if (ctrl[`MDC_C_TEST] & (dsr_state != mdc_pkg::DSR_IDLE))
      dsr_state <= mdc_pkg::DSR_IDLE;
    else
    begin
      dsr_cnt <= dsr_cnt + 26'h1;
      unique case (dsr_state)
        mdc_pkg::DSR_IDLE:
          if (ctrl[`MDC_C_DTR] & sync[1] & ~ctrl[`MDC_C_TEST] & ~dial)
            dsr_state <= mdc_pkg::DSR_DATA;
        mdc_pkg::DSR_DATA:
        begin
          dsr_cnt <= 26'h0000000;
          if (~ctrl[`MDC_C_DTR])
            dsr_state <= ctrl[`MDC_C_SPACE_DISC] ? mdc_pkg::DSR_SPACE : mdc_pkg::DSR_DROP;
        end
        mdc_pkg::DSR_SPACE:
          if (dsr_cnt == 26'(SPACE_CYC - 1))
          begin
            dsr_state <= mdc_pkg::DSR_DROP;
            dsr_cnt   <= 26'h0000000;
          end
        mdc_pkg::DSR_DROP:
          if (dsr_cnt == 26'(DROP_CYC - 1))
            dsr_state <= mdc_pkg::DSR_IDLE;
      endcase
    end
  end

  // set-ready pin from sequencer state
  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
      O_DSR <= 1'b0;
    else
      O_DSR <= (dsr_state != mdc_pkg::DSR_IDLE) & ~ctrl[`MDC_C_TEST];
  end

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_SYS_RST);

  a_rxd_clamp:
    assert property (!sync[1] |=> O_RXD)
    else $error("receive data not held at mark");
  a_dsr_test:
    assert property (ctrl[`MDC_C_TEST] |=> !O_DSR && (dsr_state == mdc_pkg::DSR_IDLE))
    else $error("set-ready on in test state");
  a_guard_pick:
    assert property (ctrl[`MDC_C_GUARD_SEL] |=> O_GUARD_MILLIHZ == `MDC_GUARD_LO_MHZ)
    else $error("wrong guard tone");
  a_dtmf_star:
    assert property (dial && txdata[3:0] == 4'hA && $stable(ctrl)
      |=> O_TONE_A_HZ == `MDC_HZ_R941 && O_TONE_B_HZ == `MDC_HZ_C1209)
    else $error("star digit tones wrong");
  a_dtmf_low4:
    assert property (dial && txdata[3:0] == 4'hE
      |=> O_TONE_A_HZ == `MDC_HZ_R941 && O_TONE_B_HZ == `MDC_HZ_C1477)
    else $error("pound digit tones wrong");
  a_carrier:
    assert property (psk && !ctrl[`MDC_C_ANS] |=> O_TONE_A_HZ == `MDC_HZ_ORIG)
    else $error("originate carrier wrong");
  a_fsk_tone:
    assert property (ctrl[`MDC_C_FSK] && !dial && ctrl[`MDC_C_ANS] && !fsk_bit
      |=> O_TONE_A_HZ == `MDC_HZ_FA_SPACE)
    else $error("answer space tone wrong");
  a_tx_half:
    assert property ($rose(O_TRANSMIT_DATA_CLOCK_OUT) && $stable(tx_half)
      |-> $past(tx_cnt) >= tx_half - 26'h1)
    else $error("transmit clock half period short");
  a_receive_data_clock_out_mid:
    assert property (!sync[3] && lclk_d |=> $rose(O_RECEIVE_DATA_CLOCK_OUT))
    else $error("receive clock not rising mid bit");
  a_dibit_pair:
    assert property (O_TX_SYM_STB && !$past(ctrl[`MDC_C_R600]) |-> $past(pair_half))
    else $error("symbol without a bit pair");
  a_phase_step:
    assert property (O_TX_SYM_STB && $past(ctrl[`MDC_C_R600])
      |-> O_TX_PHASE == $past(O_TX_PHASE) + 2'h1 || O_TX_PHASE == $past(O_TX_PHASE) + 2'h3)
    else $error("single bit phase step wrong");
  a_dsr_drop:
    assert property ($past(dsr_state) == mdc_pkg::DSR_DROP && dsr_state == mdc_pkg::DSR_IDLE
      && !$past(ctrl[`MDC_C_TEST]) |-> $past(dsr_cnt) == 26'(DROP_CYC - 1))
    else $error("set-ready dropped at wrong time");
  a_char_len:
    assert property ({1'b0, fr_cnt} < char_len)
    else $error("character count past length");

  c_dial: cover property (dial ##1 O_TONE_B_HZ == `MDC_HZ_C1633);
  c_dsr_drop: cover property ($fell(O_DSR));
  c_ferr: cover property ($rose(ferr));
  c_sym: cover property (O_TX_SYM_STB && !ctrl[`MDC_C_R600]);
endmodule // mdc_modem_coding
`default_nettype wire

// File: mdc_params.svh
// constants for the modem data and tone coding block
`ifndef MDC_PARAMS_SVH
`define MDC_PARAMS_SVH
// clock and timing figures
`define MDC_CLK_KHZ       10000
`define MDC_RATE_HI_BPS   1200
`define MDC_RATE_LO_BPS   600
`define MDC_TONE_RESP_MS  17
`define MDC_DSR_DROP_MS   50
`define MDC_SPACE_MAX_MS  4000
// register byte offsets
`define MDC_A_CTRL        8'h00
`define MDC_A_TXDATA      8'h04
`define MDC_A_STATUS      8'h08
`define MDC_A_TONE        8'h0C
// control register fields
`define MDC_C_CALL_REQ    0
`define MDC_C_DTMF        1
`define MDC_C_GUARD_SEL   2
`define MDC_C_ANS         3
`define MDC_C_R600        4
`define MDC_C_FSK         5
`define MDC_C_DTR         6
`define MDC_C_SPACE_DISC  7
`define MDC_C_TEST        8
`define MDC_C_CLEN_LO     9
`define MDC_C_CLEN_HI     10
`define MDC_CTRL_RST      11'h408
// status register fields
`define MDC_S_DSR         0
`define MDC_S_LSD         1
`define MDC_S_TONE        2
`define MDC_S_FERR        3
`define MDC_CHAR_MIN      5'h08
// line frequencies in hertz
`define MDC_HZ_ORIG       12'h4B0
`define MDC_HZ_ANS        12'h960
`define MDC_HZ_FO_MARK    12'h4F6
`define MDC_HZ_FO_SPACE   12'h42E
`define MDC_HZ_FA_MARK    12'h8B1
`define MDC_HZ_FA_SPACE   12'h7E9
`define MDC_HZ_R697       12'h2B9
`define MDC_HZ_R770       12'h302
`define MDC_HZ_R852       12'h354
`define MDC_HZ_R941       12'h3AD
`define MDC_HZ_C1209      12'h4B9
`define MDC_HZ_C1336      12'h538
`define MDC_HZ_C1477      12'h5C5
`define MDC_HZ_C1633      12'h661
// guard tones in millihertz
`define MDC_GUARD_HI_MHZ  21'h1B7740
`define MDC_GUARD_LO_MHZ  21'h087376
`endif

// File: mdc_pkg.sv
// types for the modem data and tone coding block
`default_nettype none
package mdc_pkg;
  typedef enum logic [1:0] {
    DSR_IDLE  = 2'b00,
    DSR_DATA  = 2'b01,
    DSR_SPACE = 2'b11,
    DSR_DROP  = 2'b10
  } mdc_dsr_state_type;
  typedef logic [11:0] mdc_hz_type;
endpackage
`default_nettype wire

// File: mdc_bit_if.sv
// serial bit handoff between the coder and a scrambler
`default_nettype none
interface mdc_bit_if;
  logic bit_in;
  logic stb;
  logic bit_out;
  modport core (input bit_in, input stb, output bit_out);
  modport user (output bit_in, output stb, input bit_out);
endinterface
`default_nettype wire

// File: mdc_scrambler.sv
// self-synchronising scrambler or descrambler, taps 14 and 17
`default_nettype none
module mdc_scrambler #(
  parameter bit DESCRAMBLE = 1'b0
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  mdc_bit_if.core   b
);
  logic [16:0] sr;
  logic        fb;

  // output bit mixes input with delayed line bits
  assign fb = b.bit_in ^ sr[13] ^ sr[16];

  // shift line-side bits on each strobe
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      sr        <= 17'h00000;
      b.bit_out <= 1'b0;
    end
    else if (b.stb)
    begin
      b.bit_out <= fb;
      sr        <= {sr[15:0], DESCRAMBLE ? b.bit_in : fb};
    end
  end

  a_scr_mix:
    assert property (@(posedge i_clk) disable iff (i_rst)
      b.stb |=> b.bit_out == ($past(b.bit_in) ^ $past(sr[13]) ^ $past(sr[16])))
    else $error("scrambler output does not follow taps");
endmodule // mdc_scrambler
`default_nettype wire

// File: mdc_stable_filter.sv
// level filter: output follows input after it holds steady
`default_nettype none
module mdc_stable_filter #(
  parameter int unsigned N = 170000
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_level,
  output logic      o_level
);
  localparam int unsigned W = $clog2(N + 1);
  logic [W-1:0] cnt;

  // count how long input differs from output
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt     <= '0;
      o_level <= 1'b0;
    end
    else if (i_level == o_level)
      cnt <= '0;
    else if (cnt == W'(N - 1))
    begin
      cnt     <= '0;
      o_level <= i_level;
    end
    else
      cnt <= cnt + W'(1);
  end

  a_tone_settle:
    assert property (@(posedge i_clk) disable iff (i_rst)
      $changed(o_level) |-> $past(cnt) == W'(N - 1))
    else $error("tone flag moved before settle time");
endmodule // mdc_stable_filter
`default_nettype wire

// File: mdc_line_partner.sv
// line-side model: recovered bit clock, demodulated bits, detect flags
`default_nettype none
module mdc_line_partner (
  input  wire logic i_run,
  input  wire logic i_tone,
  output logic      o_line_clk,
  output logic      o_line_bit,
  output logic      o_lsd,
  output logic      o_tone
);
  timeunit 1ns;
  timeprecision 1ns;
  int seed = 82728;
  initial o_line_clk = 1'b0;
  initial o_line_bit = 1'b0;
  // bit clock runs only while a carrier is present, 800 ns period
  always
  begin
    #400;
    o_line_clk = i_run ? ~o_line_clk : 1'b0;
  end
  // new bit at every bit start
  always @(posedge o_line_clk)
    o_line_bit = 1'($random(seed));
  // no carrier: line bit carries only noise
  always
  begin
    #100;
    if (!i_run)
      o_line_bit = ~o_line_bit;
  end
  // detector flags follow the bench's commands
  assign o_lsd  = i_run;
  assign o_tone = i_tone;
endmodule // mdc_line_partner
`default_nettype wire

// File: modem_dte_data_and_tone_coding_tb_top.sv
// self-checking bench for the modem data and tone coding block
`include "mdc_params.svh"
`default_nettype none
module modem_dte_data_and_tone_coding_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HI = 20;
  localparam int LO = 40;
  localparam logic [31:0] ROWS = 32'hF93A9503;
  localparam logic [31:0] COLS = 32'hEFC92491;
  localparam logic [11:0] ROW_HZ [4] = '{`MDC_HZ_R697, `MDC_HZ_R770, `MDC_HZ_R852, `MDC_HZ_R941};
  localparam logic [11:0] COL_HZ [4] = '{`MDC_HZ_C1209, `MDC_HZ_C1336, `MDC_HZ_C1477,
                                         `MDC_HZ_C1633};
  localparam logic [11:0] FSK_HZ [4] = '{`MDC_HZ_FO_SPACE, `MDC_HZ_FA_SPACE, `MDC_HZ_FO_MARK,
                                         `MDC_HZ_FA_MARK};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        txd = 1'b1;
  logic        run = 1'b0;
  logic        tone_in = 1'b0;
  logic [31:0] prdata;
  logic        pready, pslverr, lclk, lbit, lsd, tone, txck, rxck, rxd, dsr, sym;
  logic [1:0]  phase;
  logic [11:0] ta, tb;
  logic [20:0] guard;
  logic [32:0] q_exp[$];
  logic [31:0] q_msk[$];
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          seed = 82728;
  int          n_sym = 0;
  bit          odd_chk = 1'b0;
  logic [1:0]  last_ph = 2'h0;
  always #50 clk = ~clk;
  // device and far side
  mdc_modem_coding #(.TX_HALF_HI(HI), .TX_HALF_LO(LO), .TONE_CYC(16), .DROP_CYC(30),
    .SPACE_CYC(50)) i_dut (.I_CLK(clk), .I_SYS_RST(rst), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_TXD(txd), .I_RX_LINE_CLK(lclk),
    .I_RX_LINE_BIT(lbit), .I_LINE_SIGNAL_DETECT(lsd), .I_TONE_ENERGY(tone),
    .O_TRANSMIT_DATA_CLOCK_OUT(txck), .O_RECEIVE_DATA_CLOCK_OUT(rxck), .O_RXD(rxd),
    .O_DSR(dsr), .O_TX_PHASE(phase), .O_TX_SYM_STB(sym), .O_TONE_A_HZ(ta),
    .O_TONE_B_HZ(tb), .O_GUARD_MILLIHZ(guard));
  mdc_line_partner i_line (.i_run(run), .i_tone(tone_in), .o_line_clk(lclk),
    .o_line_bit(lbit), .o_lsd(lsd), .o_tone(tone));
  task automatic test_done();
    if (n_mismatch == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cmp_pin(input logic [32:0] got, input logic [32:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_reg(input logic [32:0] got, input logic [32:0] exp, input logic [31:0] m);
    cmp_pin(got & {1'b1, m}, exp & {1'b1, m});
  endtask
  // one transfer; a read notes its expected word and mask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e = '0, input logic [31:0] m = '1);
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    if (!w)
    begin
      q_exp.push_back(e);
      q_msk.push_back(m);
    end
    @(posedge clk);
    pen <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic pin_at(input logic got_now, input logic exp);
    cmp_pin(33'(got_now), 33'(exp));
  endtask
  // high time of the transmit clock in cycles
  task automatic half_len(input int exp);
    int n;
    @(posedge txck);
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (txck === 1'b1);
    cmp_pin(33'(n), 33'(exp + 1));
  endtask
  // random transmit bits for 800 cycles, symbols counted meanwhile
  task automatic tx_run();
    n_sym = 0;
    repeat (20)
    begin
      txd <= 1'($random(seed));
      cyc(40);
    end
    cmp_pin(33'(n_sym >= 9 && n_sym <= 11), 33'h1);
  endtask
  // read results taken off the queue at the answering edge
  always @(posedge clk)
    if (psel && pen && !pwr && pready === 1'b1)
      cmp_reg({pslverr, prdata}, q_exp.pop_front(), q_msk.pop_front());
  // each single-bit symbol must turn by an odd number of quarters
  always @(posedge clk)
    if (sym === 1'b1)
    begin
      n_sym++;
      if (odd_chk)
        cmp_pin(33'(phase[0] ^ last_ph[0]), 33'h1);
      last_ph = phase;
    end
  // watchdog
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    test_done();
  end
  // main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    apb(0, `MDC_A_CTRL, 0, 33'h408);
    apb(0, 8'h10, 0, {1'b1, 32'h0});
    apb(0, `MDC_A_TONE, 0, {21'h0, `MDC_HZ_ANS});
    apb(1, `MDC_A_CTRL, 0);
    cyc(2);
    apb(0, `MDC_A_TONE, 0, {21'h0, `MDC_HZ_ORIG});
    for (int k = 0; k < 4; k++)
    begin
      apb(1, `MDC_A_CTRL, 32'(k) << 9);
      apb(0, `MDC_A_CTRL, 0, 33'(k) << 9);
    end
    apb(1, `MDC_A_CTRL, 32'h4);
    cyc(2);
    cmp_pin(33'(guard), 33'(`MDC_GUARD_LO_MHZ));
    apb(1, `MDC_A_CTRL, 32'h0);
    cyc(2);
    cmp_pin(33'(guard), 33'(`MDC_GUARD_HI_MHZ));
    cyc(100);
    half_len(HI);
    tx_run();
    apb(1, `MDC_A_CTRL, 32'h10);
    cyc(200);
    half_len(LO);
    odd_chk = 1'b1;
    tx_run();
    odd_chk = 1'b0;
    apb(1, `MDC_A_CTRL, 32'h3);
    for (int c = 0; c < 16; c++)
    begin
      apb(1, `MDC_A_TXDATA, {24'h0, 4'($random(seed)), 4'(c)});
      cyc(2);
      apb(0, `MDC_A_TONE, 0,
          {5'h0, COL_HZ[COLS[2*c+:2]], 4'h0, ROW_HZ[ROWS[2*c+:2]]});
    end
    for (int i = 0; i < 4; i++)
    begin
      apb(1, `MDC_A_CTRL, 32'h20 | (32'(i % 2) << 3));
      txd <= 1'(i / 2);
      cyc(120);
      apb(0, `MDC_A_TONE, 0, {21'h0, FSK_HZ[i]});
    end
    apb(1, `MDC_A_CTRL, 32'h1);
    tone_in <= 1'b1;
    cyc(2);
    apb(0, `MDC_A_STATUS, 0, 33'h0, 32'h4);
    cyc(30);
    apb(0, `MDC_A_STATUS, 0, 33'h4, 32'h4);
    apb(1, `MDC_A_CTRL, 32'h0);
    cyc(30);
    apb(0, `MDC_A_STATUS, 0, 33'h0, 32'h4);
    tone_in <= 1'b0;
    run <= 1'b1;
    apb(1, `MDC_A_CTRL, 32'h40);
    cyc(60);
    @(negedge clk);
    pin_at(dsr, 1'b1);
    // line traffic judged only once set-ready is on
    repeat (4)
    begin
      @(posedge rxck);
      pin_at(lclk, 1'b0);
    end
    apb(1, `MDC_A_CTRL, 32'h140);
    cyc(3);
    @(negedge clk);
    pin_at(dsr, 1'b0);
    apb(1, `MDC_A_CTRL, 32'h40);
    cyc(10);
    @(negedge clk);
    pin_at(dsr, 1'b1);
    apb(1, `MDC_A_CTRL, 32'h0);
    cyc(15);
    @(negedge clk);
    pin_at(dsr, 1'b1);
    cyc(30);
    @(negedge clk);
    pin_at(dsr, 1'b0);
    apb(1, `MDC_A_CTRL, 32'hC0);
    cyc(20);
    apb(1, `MDC_A_CTRL, 32'h80);
    cyc(60);
    @(negedge clk);
    pin_at(dsr, 1'b1);
    cyc(40);
    @(negedge clk);
    pin_at(dsr, 1'b0);
    run <= 1'b0;
    cyc(8);
    repeat (20)
    begin
      @(negedge clk);
      pin_at(rxd, 1'b1);
    end
    test_done();
  end
endmodule // modem_dte_data_and_tone_coding_tb_top
`default_nettype wire
